// >>> rtl/vic_top.sv
// Contract
// RULE1 - Pin 1 edge field: off, rise, fall, both
// RULE2 - Pin 0 edge field same, bits 1:0
// RULE3 - Edge bits 7:4 read zero; reset zero
// RULE4 - Control 0 layout: flags, enables, global enable
// RULE5 - Control 1 layout: timer, A/D, pin 1
// RULE6 - Control 2 layout: time bases, periodic timer
// RULE7 - Control 3: low-voltage flag and enable only
// RULE8 - Event sets its flag regardless of enables
// RULE9 - Vector only while source enable set
// RULE10 - Global enable clear suppresses all vectoring
// RULE11 - Two pins plus internal sources, each flagged
// RULE12 - Servicing clears global enable; flags still recorded
// RULE13 - No acknowledge while return stack is full
// RULE14 - Servicing clears that source's flag
// RULE15 - New flag wakes standby; old flag does not
// RULE16 - Simultaneous requests served lowest vector first
// RULE17 - Pins synchronised by two flip-flops
//
// Local design decisions: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module vic_top
    import vic_pkg::*;
(
    input  wire logic         ref_clk_in,
    input  wire logic         arst_n_in,
    input  wire vic_axi_req_s axi_req_in,
    output vic_axi_rsp_s      axi_rsp_out,
    input  wire logic         ext_irq_pin0_in,
    input  wire logic         ext_irq_pin1_in,
    input  wire vic_evt_s     evt_in,
    input  wire logic         stack_full_in,
    input  wire logic         sleep_in,
    input  wire logic         svc_ack_in,
    output logic              vec_req_out,
    output logic [3:0]        vec_idx_out,
    output logic              wake_out,
    output logic              irq_out
);

    vic_state_s      r_r;
    vic_state_s      r_nxt;
    logic [1:0]      pin_hit;
    logic [NSRC-1:0] set_vec;
    logic            svc;
    logic            aw_hs;
    logic            w_hs;
    logic            ar_hs;

    ////////////////////////////////////////////////////////////////////////
    // Address decode, register read and priority helpers

    function automatic logic addr_ok(input logic [31:0] a);
        logic [5:0] i;
        i = a[ADDR_MSB:ADDR_LSB];
        addr_ok = (a[31:ADDR_MSB+1] == '0) && (i <= IDX_EVT_MSK);
    endfunction

    function automatic logic [5:0] addr_idx(input logic [31:0] a);
        addr_idx = a[ADDR_MSB:ADDR_LSB];
    endfunction

    function automatic logic [7:0] ctrl_rd(
        input logic [1:0]      c,
        input logic [NSRC-1:0] fl,
        input logic [NSRC-1:0] en,
        input logic            global_irq_enable
    );
        logic [7:0] b;
        logic [3:0] fm;
        logic [3:0] em;
        b = RST_BYTE;
        for (int s = 0; s < 4; s++)
        begin
            fm = FLAG_MAP[c][s];
            em = EN_MAP[c][s];
            if (fm != SRC_NONE)
                b[FLAG_LSB+s] = fl[fm]; // RULE4 RULE5 RULE6 RULE7
            if (em != SRC_NONE)
                b[s] = en[em];
        end
        if (c == 2'd0)
            b[EMI_BIT] = global_irq_enable; // RULE4
        ctrl_rd = b;
    endfunction

    function automatic logic [31:0] reg_rd(
        input logic [5:0] i,
        input vic_state_s st
    );
        logic [31:0] d;
        d = '0;
        if (i == IDX_EDGE)
            d[SEL_W-1:0] = st.sel; // RULE3
        else if (i <= IDX_CTRL3)
            d[7:0] = ctrl_rd(2'(i - IDX_CTRL0), st.flag, st.en, st.global_irq_enable);
        else if (i == IDX_EVT_ST)
            d[NEVT-1:0] = st.evt_st;
        else
            d[NEVT-1:0] = st.evt_msk;
        reg_rd = d;
    endfunction

    function automatic logic [3:0] prio(input logic [NSRC-1:0] v);
        prio = '0;
        for (int k = NSRC - 1; k >= 0; k--)
        begin
            if (v[k])
                prio = 4'(k); // RULE16
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // External pin edge detection

    vic_edge_det u_pin0 (
        .ref_clk_in (ref_clk_in),
        .arst_n_in  (arst_n_in),
        .pin_in     (ext_irq_pin0_in),
        .sel_in     (r_r.sel[SEL0_LSB+:2]), // RULE2
        .hit_out    (pin_hit[0])
    );

    vic_edge_det u_pin1 (
        .ref_clk_in (ref_clk_in),
        .arst_n_in  (arst_n_in),
        .pin_in     (ext_irq_pin1_in),
        .sel_in     (r_r.sel[SEL1_LSB+:2]), // RULE1
        .hit_out    (pin_hit[1])
    );

    // Source index order is the vector order
    assign set_vec = {evt_in.lowvolt_detect,
                      evt_in.timebase1,
                      evt_in.timebase0,
                      pin_hit[1],
                      evt_in.adc_done,
                      evt_in.per_timer_a,
                      evt_in.per_timer_p,
                      evt_in.std_timer_a,
                      evt_in.std_timer_p,
                      evt_in.overvolt_protect,
                      evt_in.overcurr_protect,
                      pin_hit[0]}; // RULE11

    ////////////////////////////////////////////////////////////////////////
    // CPU request side

    assign vec_req_out = r_r.pend & r_r.global_irq_enable & ~stack_full_in; // RULE10 RULE13
    assign vec_idx_out = r_r.idx;
    assign svc         = svc_ack_in & vec_req_out;
    assign wake_out    = r_r.wake;
    assign irq_out     = |(r_r.evt_st & r_r.evt_msk);

    ////////////////////////////////////////////////////////////////////////
    // Bus handshakes

    assign axi_rsp_out.awready = ~r_r.aw_got & ~r_r.bvalid;
    assign axi_rsp_out.wready  = ~r_r.w_got & ~r_r.bvalid;
    assign axi_rsp_out.bvalid  = r_r.bvalid;
    assign axi_rsp_out.bresp   = r_r.bresp;
    assign axi_rsp_out.arready = ~r_r.rvalid;
    assign axi_rsp_out.rvalid  = r_r.rvalid;
    assign axi_rsp_out.rdata   = r_r.rdata;
    assign axi_rsp_out.rresp   = r_r.rresp;

    assign aw_hs = axi_req_in.awvalid & axi_rsp_out.awready;
    assign w_hs  = axi_req_in.wvalid & axi_rsp_out.wready;
    assign ar_hs = axi_req_in.arvalid & axi_rsp_out.arready;

    ////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb
    begin
        logic [5:0]      wi;
        logic [1:0]      c;
        logic [3:0]      fm;
        logic [3:0]      em;
        logic [NSRC-1:0] fl_old;
        logic [NEVT-1:0] evt_set;
        wi      = addr_idx(r_r.awaddr);
        c       = 2'(wi - IDX_CTRL0);
        fm      = SRC_NONE;
        em      = SRC_NONE;
        fl_old  = r_r.flag;
        evt_set = '0;
        r_nxt   = r_r;

        // Write channel capture, either order
        if (aw_hs)
        begin
            r_nxt.aw_got = 1'b1;
            r_nxt.awaddr = axi_req_in.awaddr;
        end
        if (w_hs)
        begin
            r_nxt.w_got = 1'b1;
            r_nxt.wbyte = axi_req_in.wdata[7:0];
            r_nxt.wen   = axi_req_in.wstrb[0];
        end
        if (r_r.bvalid && axi_req_in.bready)
            r_nxt.bvalid = 1'b0;

        // Servicing the current vector
        if (svc)
        begin
            r_nxt.flag[r_r.idx] = 1'b0; // RULE14
            r_nxt.global_irq_enable           = 1'b0; // RULE12
        end

        // Register write once address and data are both held
        if (r_r.aw_got && r_r.w_got)
        begin
            r_nxt.aw_got = 1'b0;
            r_nxt.w_got  = 1'b0;
            r_nxt.bvalid = 1'b1;
            r_nxt.bresp  = addr_ok(r_r.awaddr) ? RESP_OKAY : RESP_SLVERR;
            if (addr_ok(r_r.awaddr) && r_r.wen)
            begin
                if (wi == IDX_EDGE)
                    r_nxt.sel = r_r.wbyte[SEL_W-1:0]; // RULE3
                else if (wi <= IDX_CTRL3)
                begin
                    for (int s = 0; s < 4; s++)
                    begin
                        fm = FLAG_MAP[c][s];
                        em = EN_MAP[c][s];
                        if (fm != SRC_NONE)
                            r_nxt.flag[fm] = r_r.wbyte[FLAG_LSB+s];
                        if (em != SRC_NONE)
                            r_nxt.en[em] = r_r.wbyte[s]; // RULE5 RULE6
                    end
                    if (c == 2'd0)
                        r_nxt.global_irq_enable = r_r.wbyte[EMI_BIT]; // RULE4
                end
                else if (wi == IDX_EVT_ST)
                    r_nxt.evt_st = r_r.evt_st & ~r_r.wbyte[NEVT-1:0];
                else
                    r_nxt.evt_msk = r_r.wbyte[NEVT-1:0];
            end
        end

        // Hardware events win over any clear in the same cycle
        r_nxt.flag = r_nxt.flag | set_vec; // RULE8

        // Wake only on a flag newly set during standby
        r_nxt.wake = sleep_in & (|(r_nxt.flag & ~fl_old)); // RULE15

        // Pending request and its vector, lowest index first
        r_nxt.pend = |(r_r.flag & r_r.en); // RULE9
        r_nxt.idx  = prio(r_r.flag & r_r.en); // RULE16

        // Block status events
        evt_set[EVT_SVC]  = svc;
        evt_set[EVT_HOLD] = r_r.pend & r_r.global_irq_enable & stack_full_in; // RULE13
        evt_set[EVT_WAKE] = r_nxt.wake;
        r_nxt.evt_st      = r_nxt.evt_st | evt_set;

        // Read channel
        if (r_r.rvalid && axi_req_in.rready)
            r_nxt.rvalid = 1'b0;
        if (ar_hs)
        begin
            r_nxt.rvalid = 1'b1;
            if (addr_ok(axi_req_in.araddr))
            begin
                r_nxt.rdata = reg_rd(addr_idx(axi_req_in.araddr), r_r);
                r_nxt.rresp = RESP_OKAY;
            end
            else
            begin
                r_nxt.rdata = '0;
                r_nxt.rresp = RESP_SLVERR;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge ref_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
            r_r <= '0; // RULE3 RULE4 RULE5 RULE6 RULE7
        else
            r_r <= r_nxt;
    end

endmodule
`default_nettype wire

// >>> rtl/vic_pkg.sv
package vic_pkg;

    localparam int          NSRC        = 12;
    localparam int          NEVT        = 3;
    localparam logic [3:0]  SRC_NONE    = 4'hf;

    // Word index of each register, byte address is four times this
    localparam logic [5:0]  IDX_EDGE    = 6'h00;
    localparam logic [5:0]  IDX_CTRL0   = 6'h01;
    localparam logic [5:0]  IDX_CTRL3   = 6'h04;
    localparam logic [5:0]  IDX_EVT_ST  = 6'h05;
    localparam logic [5:0]  IDX_EVT_MSK = 6'h06;
    localparam int          ADDR_LSB    = 2;
    localparam int          ADDR_MSB    = 7;

    localparam int          SEL0_LSB    = 0;
    localparam int          SEL1_LSB    = 2;
    localparam int          SEL_W       = 4;
    localparam int          FLAG_LSB    = 4;
    localparam int          EMI_BIT     = 0;
    localparam logic [7:0]  RST_BYTE    = 8'h00;

    localparam int          EVT_SVC     = 0;
    localparam int          EVT_HOLD    = 1;
    localparam int          EVT_WAKE    = 2;

    localparam logic [1:0]  RESP_OKAY   = 2'b00;
    localparam logic [1:0]  RESP_SLVERR = 2'b10;

    // Source index per slot; slot s is flag bit 4+s and enable bit s
    localparam logic [3:0]  FLAG_MAP [0:3][0:3] = '{
        '{4'h1, 4'h2, 4'h0, 4'hf},
        '{4'h8, 4'h7, 4'h3, 4'h4},
        '{4'h5, 4'h6, 4'h9, 4'ha},
        '{4'hb, 4'hf, 4'hf, 4'hf}};
    localparam logic [3:0]  EN_MAP [0:3][0:3] = '{
        '{4'hf, 4'h1, 4'h2, 4'h0},
        '{4'h8, 4'h7, 4'h3, 4'h4},
        '{4'h5, 4'h6, 4'h9, 4'ha},
        '{4'hb, 4'hf, 4'hf, 4'hf}};

    typedef enum logic [1:0] {
        EDGE_OFF  = 2'b00,
        EDGE_RISE = 2'b01,
        EDGE_FALL = 2'b10,
        EDGE_BOTH = 2'b11
    } vic_edge_e;

    typedef struct packed {
        logic       lowvolt_detect;
        logic       timebase1;
        logic       timebase0;
        logic       adc_done;
        logic       per_timer_a;
        logic       per_timer_p;
        logic       std_timer_a;
        logic       std_timer_p;
        logic       overvolt_protect;
        logic       overcurr_protect;
    } vic_evt_s;

    typedef struct packed {
        logic        awvalid;
        logic [31:0] awaddr;
        logic        wvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bready;
        logic        arvalid;
        logic [31:0] araddr;
        logic        rready;
    } vic_axi_req_s;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } vic_axi_rsp_s;

    typedef struct packed {
        logic        meta;
        logic        sync;
        logic        prev;
    } vic_edge_s;

    typedef struct packed {
        logic [SEL_W-1:0] sel;
        logic [NSRC-1:0]  flag;
        logic [NSRC-1:0]  en;
        logic             global_irq_enable;
        logic [NEVT-1:0]  evt_st;
        logic [NEVT-1:0]  evt_msk;
        logic             pend;
        logic [3:0]       idx;
        logic             wake;
        logic             aw_got;
        logic             w_got;
        logic [31:0]      awaddr;
        logic [7:0]       wbyte;
        logic             wen;
        logic             bvalid;
        logic [1:0]       bresp;
        logic             rvalid;
        logic [31:0]      rdata;
        logic [1:0]       rresp;
    } vic_state_s;

endpackage

// >>> rtl/vic_edge_det.sv
`timescale 1ns/1ps
`default_nettype none
module vic_edge_det
    import vic_pkg::*;
(
    input  wire logic       ref_clk_in,
    input  wire logic       arst_n_in,
    input  wire logic       pin_in,
    input  wire logic [1:0] sel_in,
    output logic            hit_out
);

    vic_edge_s r_r;
    vic_edge_s r_nxt;
    logic      rise;
    logic      fall;

    ////////////////////////////////////////////////////////////////////////
    // Two-stage synchroniser, then edge compare on the second stage
    always_comb
    begin
        r_nxt      = r_r;
        r_nxt.meta = pin_in; // RULE17
        r_nxt.sync = r_r.meta; // RULE17
        r_nxt.prev = r_r.sync;
    end

    always_ff @(posedge ref_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
            r_r <= '0;
        else
            r_r <= r_nxt;
    end

    assign rise = r_r.sync & ~r_r.prev;
    assign fall = ~r_r.sync & r_r.prev;

    always_comb
    begin
        unique case (vic_edge_e'(sel_in))
            EDGE_OFF:  hit_out = 1'b0; // RULE1 RULE2
            EDGE_RISE: hit_out = rise;
            EDGE_FALL: hit_out = fall;
            EDGE_BOTH: hit_out = rise | fall;
        endcase
    end

endmodule
`default_nettype wire

// >>> testbench/vic_top_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module vic_top_asserts
    import vic_pkg::*;
(
    input wire logic         ref_clk_in,
    input wire logic         arst_n_in,
    input wire vic_axi_req_s axi_req_in,
    input wire vic_axi_rsp_s axi_rsp_out,
    input wire logic         stack_full_in,
    input wire logic         sleep_in,
    input wire logic         svc_ack_in,
    input wire logic         vec_req_out,
    input wire logic [3:0]   vec_idx_out,
    input wire logic         wake_out
);
    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (!arst_n_in);
    ////////////////////////////////////////
    a_full_blocks: assert property (stack_full_in |-> !vec_req_out)
        else $error("request while stack full");
    a_svc_drops: assert property (svc_ack_in && vec_req_out |=> !vec_req_out)
        else $error("request stays after service");
    a_idx_range: assert property (vec_req_out |-> vec_idx_out < 4'hc)
        else $error("vector index out of range");
    a_wake_pulse: assert property (wake_out |=> !wake_out)
        else $error("wake longer than one cycle");
    a_wake_sleep: assert property (wake_out |-> $past(sleep_in))
        else $error("wake while awake");
    a_rd_answer: assert property (axi_req_in.arvalid && axi_rsp_out.arready
        |=> axi_rsp_out.rvalid)
        else $error("read answer late");
    a_rd_stands: assert property (axi_rsp_out.rvalid && !axi_req_in.rready
        |=> axi_rsp_out.rvalid && $stable(axi_rsp_out.rdata))
        else $error("read data dropped");
    a_wr_answer: assert property (axi_req_in.awvalid && axi_rsp_out.awready
        && axi_req_in.wvalid && axi_rsp_out.wready |-> ##2 axi_rsp_out.bvalid)
        else $error("write answer late");
    a_ar_refused: assert property (axi_rsp_out.rvalid |-> !axi_rsp_out.arready)
        else $error("read taken while busy");
    a_unmapped_rd: assert property (axi_req_in.arvalid && axi_rsp_out.arready
        && axi_req_in.araddr[7:2] > 6'h06 |=> axi_rsp_out.rresp == RESP_SLVERR
        && axi_rsp_out.rdata == 32'h0)
        else $error("unmapped read answered");
    c_service: cover property (svc_ack_in && vec_req_out);
    c_wake: cover property (wake_out);
    c_held: cover property (stack_full_in && $past(vec_req_out));
endmodule
bind vic_top vic_top_asserts i_vic_top_asserts (.ref_clk_in, .arst_n_in,
    .axi_req_in, .axi_rsp_out, .stack_full_in, .sleep_in, .svc_ack_in,
    .vec_req_out, .vec_idx_out, .wake_out);
`default_nettype wire

// >>> testbench/vic_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
module vic_cpu_model
(
    input  wire logic       ref_clk_in,
    input  wire logic       arst_n_in,
    input  wire logic       vec_req_in,
    input  wire logic [3:0] vec_idx_in,
    input  wire logic [1:0] dly_in,
    output logic            svc_ack_out,
    output logic [3:0]      last_idx_out,
    output logic [7:0]      served_out
);
    logic [1:0] wait_r;
    logic       cool_r;
    // Takes a vector after a chosen delay, then rests two cycles
    always_ff @(posedge ref_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            svc_ack_out  <= 1'b0;
            cool_r       <= 1'b0;
            wait_r       <= 2'h0;
            last_idx_out <= 4'h0;
            served_out   <= 8'h00;
        end
        else
        begin
            svc_ack_out <= 1'b0;
            cool_r      <= svc_ack_out;
            if (vec_req_in && !svc_ack_out && !cool_r)
            begin
                if (wait_r >= dly_in)
                begin
                    svc_ack_out  <= 1'b1;
                    last_idx_out <= vec_idx_in;
                    served_out   <= served_out + 8'h01;
                    wait_r       <= 2'h0;
                end
                else
                    wait_r <= wait_r + 2'h1;
            end
        end
    end
endmodule
`default_nettype wire

// >>> testbench/tb_vectored_interrupt_control.sv
`timescale 1ns/1ps
`default_nettype none
module tb_vectored_interrupt_control
    import vic_pkg::*;
;
    logic         clk, arst_n, pin0, pin1, full, sleep, ack, vreq, wake, irq;
    vic_axi_req_s req;
    vic_axi_rsp_s rsp;
    vic_evt_s     evt;
    logic [3:0]   vidx, last;
    logic [7:0]   served, d;
    logic [1:0]   dly, rres, bres;
    logic [31:0]  rdat;
    int           bad_count, checks_done, seed, wakes;
    int           ev_reg [10] = '{1, 1, 2, 2, 3, 3, 2, 3, 3, 4};
    int           ev_bit [10] = '{4, 5, 6, 7, 4, 5, 5, 6, 7, 4};
    int           pri [3] = '{2, 3, 7};
    logic [7:0]   msk [5] = '{8'h0f, 8'h7e, 8'hff, 8'hff, 8'h11};
    vic_top i_vic_top (.ref_clk_in(clk), .arst_n_in(arst_n), .axi_req_in(req),
        .axi_rsp_out(rsp), .ext_irq_pin0_in(pin0), .ext_irq_pin1_in(pin1),
        .evt_in(evt), .stack_full_in(full), .sleep_in(sleep), .svc_ack_in(ack),
        .vec_req_out(vreq), .vec_idx_out(vidx), .wake_out(wake), .irq_out(irq));
    vic_cpu_model i_vic_cpu_model (.ref_clk_in(clk), .arst_n_in(arst_n),
        .vec_req_in(vreq), .vec_idx_in(vidx), .dly_in(dly),
        .svc_ack_out(ack), .last_idx_out(last), .served_out(served));
    ////////////////////////////////////////
    function automatic logic edge_hit(input int m, input logic rise);
        return rise ? m[0] : m[1];
    endfunction
    task automatic chk(input string n, input logic [31:0] got, exp);
        checks_done++;
        if (got !== exp)
        begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", n, exp, got);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic wr(input int i, input logic [7:0] v);
        logic aw;
        logic w;
        aw = 1'b0;
        w = 1'b0;
        req.awvalid <= 1'b1;
        req.awaddr  <= {24'h0, i[5:0], 2'b00};
        req.wvalid  <= 1'b1;
        req.wdata   <= {24'h0, v};
        req.wstrb   <= 4'hf;
        while (!(aw && w))
        begin
            @(posedge clk);
            aw = aw | rsp.awready;
            w = w | rsp.wready;
            req.awvalid <= !aw;
            req.wvalid  <= !w;
        end
        req.bready <= 1'b1;
        do @(posedge clk); while (rsp.bvalid !== 1'b1);
        bres = rsp.bresp;
        req.bready <= 1'b0;
    endtask
    task automatic rd(input int i);
        req.arvalid <= 1'b1;
        req.araddr  <= {24'h0, i[5:0], 2'b00};
        do @(posedge clk); while (rsp.arready !== 1'b1);
        req.arvalid <= 1'b0;
        req.rready  <= 1'b1;
        do @(posedge clk); while (rsp.rvalid !== 1'b1);
        rdat = rsp.rdata;
        rres = rsp.rresp;
        req.rready <= 1'b0;
    endtask
    task automatic rchk(input int i, input logic [7:0] e);
        rd(i);
        chk($sformatf("reg %0d", i), rdat, {24'h0, e});
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    ////////////////////////////////////////
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk)
        if (wake === 1'b1)
            wakes++;
    initial
    begin
        tick(30000);
        bad_count++;
        wrap_up();
    end
    initial
    begin
        {arst_n, pin0, pin1, full, sleep, dly} = '0;
        {req, evt, bad_count, checks_done, wakes} = '0;
        seed = 9;
        tick(2);
        arst_n <= 1'b1;
        for (int i = 0; i < 7; i++)
            rchk(i, 8'h00);
        rd(7);
        chk("unmapped", {30'h0, rres}, {30'h0, RESP_SLVERR});
        wr(7, 8'hff);
        chk("unmapped wr", {30'h0, bres}, {30'h0, RESP_SLVERR});
        repeat (4)
            for (int i = 0; i < 5; i++)
            begin
                d = 8'($random(seed));
                // Global enable kept low so no vector disturbs readback
                wr(i, (i == 1) ? (d & 8'hfe) : d);
                chk("bresp", {30'h0, bres}, {30'h0, RESP_OKAY});
                rchk(i, d & msk[i]);
            end
        for (int i = 0; i < 5; i++)
            wr(i, 8'h00);
        for (int k = 0; k < 10; k++)
        begin
            evt <= vic_evt_s'(10'h001 << k);
            @(posedge clk);
            evt <= '0;
            rchk(ev_reg[k], 8'h01 << ev_bit[k]);
            wr(ev_reg[k], 8'h00);
        end
        for (int p = 0; p < 2; p++)
            for (int m = 0; m < 4; m++)
            begin
                wr(0, 8'(m << (2 * p)));
                for (int r = 1; r >= 0; r--)
                begin
                    if (p == 0)
                        pin0 <= r[0];
                    else
                        pin1 <= r[0];
                    tick(6);
                    rchk(1 + p, 8'(edge_hit(m, r[0])) << (6 - 2 * p));
                    wr(1 + p, 8'h00);
                end
            end
        wr(1, 8'h02);
        evt <= vic_evt_s'(10'h001);
        @(posedge clk);
        evt <= '0;
        tick(5);
        chk("served", {24'h0, served}, 32'h0);
        dly <= 2'($random(seed));
        wr(1, 8'h13);
        tick(8);
        chk("served", {24'h0, served}, 32'h1);
        chk("index", {28'h0, last}, 32'h1);
        rchk(1, 8'h02);
        full <= 1'b1;
        wr(2, 8'h0f);
        evt <= vic_evt_s'(10'h046);
        @(posedge clk);
        evt <= '0;
        wr(1, 8'h25);
        tick(5);
        chk("served", {24'h0, served}, 32'h1);
        full <= 1'b0;
        for (int j = 0; j < 3; j++)
        begin
            if (j > 0)
                wr(1, 8'h05);
            tick(8);
            chk("index", {28'h0, last}, 32'(pri[j]));
        end
        rchk(5, 8'h03);
        wr(2, 8'h00);
        sleep <= 1'b1;
        for (int j = 0; j < 2; j++)
        begin
            evt <= vic_evt_s'(10'h080);
            @(posedge clk);
            evt <= '0;
            tick(3);
            chk("wakes", 32'(wakes), 32'h1);
        end
        sleep <= 1'b0;
        rchk(5, 8'h07);
        wr(6, 8'h04);
        tick(2);
        chk("irq", {31'h0, irq}, 32'h1);
        wr(6, 8'h00);
        tick(2);
        chk("irq", {31'h0, irq}, 32'h0);
        wr(6, 8'h07);
        wr(5, 8'h07);
        tick(2);
        chk("irq", {31'h0, irq}, 32'h0);
        rchk(5, 8'h00);
        wrap_up();
    end
endmodule
`default_nettype wire
